// ---- rtl/drive_ctl_defs.svh ----
// register offsets, reset values and fixed parameter codes of the method selector
`ifndef DRIVE_CTL_DEFS_SVH
`define DRIVE_CTL_DEFS_SVH
`define OFS_METHOD_SEL 4'h0
`define OFS_SECOND_SEL 4'h1
`define OFS_CAPACITY 4'h2
`define OFS_POLES 4'h3
`define OFS_MOTOR_TYPE 4'h4
`define OFS_SECOND_CAPACITY 4'h5
`define OFS_SECOND_POLES 4'h6
`define OFS_SECOND_TYPE 4'h7
`define OFS_FREQ_PARAM 4'h8
`define OFS_PERCENT_PARAM 4'h9
`define OFS_CONFIG 4'hA
`define OFS_STATUS 4'hB
`define OFS_IRQ_STATUS 4'hC
`define OFS_IRQ_MASK 4'hD
`define RST_METHOD_SEL 16'h0028
`define RST_SECOND_SEL 16'h270F
`define RST_MOTOR_PARAM 16'h270F
`define RST_FREQ_PARAM 16'h012C
`define RST_PERCENT_PARAM 16'h0096
`define VAL_UNSET 16'h270F
`define VAL_FREQ_HIGH 16'h012C
`define VAL_FREQ_LOW 16'h0032
`define VAL_PERCENT_LOW 16'h0096
`define VAL_PERCENT_HIGH 16'h00C8
`define CFG_OPTION_BIT 0
`define CFG_SMALL_UNIT_BIT 1
`define CFG_NORMAL_DUTY_BIT 2
`define IRQ_REFUSED_BIT 0
`define IRQ_STARTED_BIT 1
`define IRQ_REWRITE_BIT 2
`endif

// ---- rtl/drive_ctl_pkg.sv ----
// types and selector decoding functions of the method selector
package drive_ctl_pkg;
    // control method chosen by a selector setting
    typedef enum logic [2:0] {
        M_VF, M_FLUX, M_REAL_SENSORLESS, M_PM_SENSORLESS, M_VECTOR, M_VECTOR_TEST, M_PM_TEST, M_NONE
    } method_t;
    // control mode
    typedef enum logic [1:0] {MODE_SPEED, MODE_TORQUE, MODE_POSITION} mode_t;
    // start sequence state
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_REFUSED} start_t;

    // setting to method; setting 10 follows the motor type
    function automatic method_t method_of(input logic [15:0] sel, input logic pm);
        method_t m;
        m = M_NONE;
        case (sel)
            16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005: m = M_VECTOR;
            16'h0009: m = M_VECTOR_TEST;
            16'h000A: m = pm ? M_PM_SENSORLESS : M_REAL_SENSORLESS;
            16'h000B, 16'h000C: m = M_REAL_SENSORLESS;
            16'h000D, 16'h000E: m = M_PM_SENSORLESS;
            16'h0013: m = M_PM_TEST;
            16'h0014: m = M_FLUX;
            16'h0028: m = M_VF;
            default: m = M_NONE;
        endcase
        return m;
    endfunction

    // true for the plain and flux methods that have no vector loop
    function automatic logic is_simple(input method_t m);
        return (m == M_VF) || (m == M_FLUX);
    endfunction
endpackage

// ---- rtl/method_if.sv ----
// carrier between the selector top and its method decoder
`timescale 1ns/10ps
interface method_if;
    logic [15:0] sel; // effective selector setting
    logic pm_motor; // applied motor type is pm
    logic mode_sw; // synchronised mode switch level
    logic option_ok; // vector option fitted
    drive_ctl_pkg::method_t method; // decoded method
    drive_ctl_pkg::mode_t mode; // decoded mode
    logic type_ok; // motor type matches, setting legal and option fitted for vector settings
    modport dec (input sel, input pm_motor, input mode_sw, input option_ok, output method, output mode,
        output type_ok);
    modport use_side (output sel, output pm_motor, output mode_sw, output option_ok, input method,
        input mode, input type_ok);
endinterface

// ---- rtl/method_decoder.sv ----
// decodes the effective setting into method, mode and motor type check
`timescale 1ns/10ps
module method_decoder (
    method_if.dec mi
);
    // settings needing an induction motor
    wire needs_im = (mi.sel <= 16'h0005) || (mi.sel == 16'h000B) || (mi.sel == 16'h000C) ||
        (mi.sel == 16'h0014);
    // settings needing a pm motor
    wire needs_pm = (mi.sel == 16'h000D) || (mi.sel == 16'h000E) || (mi.sel == 16'h0013);
    wire is_vec = (mi.method == drive_ctl_pkg::M_VECTOR) || (mi.method == drive_ctl_pkg::M_VECTOR_TEST);

    assign mi.method = drive_ctl_pkg::method_of(mi.sel, mi.pm_motor);
    // motor type, legality and option check
    assign mi.type_ok = (mi.method != drive_ctl_pkg::M_NONE) && !(needs_im && mi.pm_motor) &&
        !(needs_pm && !mi.pm_motor) && !(is_vec && !mi.option_ok);

    // mode from setting and switch input
    always_comb begin
        case (mi.sel)
            16'h0001, 16'h000B: mi.mode = drive_ctl_pkg::MODE_TORQUE;
            16'h0003, 16'h000D: mi.mode = drive_ctl_pkg::MODE_POSITION;
            16'h0002, 16'h000C: mi.mode = mi.mode_sw ? drive_ctl_pkg::MODE_TORQUE : drive_ctl_pkg::MODE_SPEED;
            16'h0004, 16'h000E: mi.mode = mi.mode_sw ? drive_ctl_pkg::MODE_POSITION : drive_ctl_pkg::MODE_SPEED;
            16'h0005: mi.mode = mi.mode_sw ? drive_ctl_pkg::MODE_TORQUE : drive_ctl_pkg::MODE_POSITION;
            default: mi.mode = drive_ctl_pkg::MODE_SPEED;
        endcase
    end
endmodule

// ---- rtl/drive_control_method_selector.sv ----
// control method selector with start check, mode switch and parameter rewrites
`timescale 1ns/10ps
`include "drive_ctl_defs.svh"
module drive_control_method_selector (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic START,
    input wire logic MODE_SWITCH,
    input wire logic SECOND_MOTOR,
    output logic RUN_PERMIT,
    output logic SETTING_ERROR_ALARM,
    output logic [2:0] METHOD,
    output logic [1:0] MODE,
    output logic IRQ
);
    // parameter registers
    logic [15:0] sel_q; // control_method_select
    logic [15:0] sel2_q; // second_motor_method_select
    logic [15:0] cap_q; // motor_capacity_param
    logic [15:0] poles_q; // motor_pole_count_param
    logic type_q; // applied_motor_type, 1 = pm
    logic [15:0] cap2_q; // second_motor_capacity_param
    logic [15:0] poles2_q; // second_motor_pole_count_param
    logic type2_q; // second_applied_motor_type
    logic [15:0] freq_q; // auto_adjusted_frequency_param, 0.01 Hz units
    logic [15:0] pct_q; // auto_adjusted_percent_param, percent
    logic [2:0] cfg_q; // option fitted, small unit, normal_duty_rating
    logic [2:0] irq_st_q; // sticky events
    logic [2:0] irq_mask_q; // event enables
    // pin synchronisers
    logic [2:0] pin_s1_q; // first stage, read only by second stage
    logic [2:0] pin_s2_q; // second stage
    logic start_prev_q; // for start edge
    drive_ctl_pkg::start_t state_q; // start sequence
    drive_ctl_pkg::start_t state_d;
    // registered outputs
    logic [15:0] rdata_q;
    logic run_q;
    logic alarm_q;
    logic [2:0] method_q;
    logic [1:0] mode_q;
    logic irq_q;
    // write side next values
    logic [15:0] freq_d;
    logic [15:0] pct_d;
    logic [2:0] irq_st_d;

    method_if mi ();
    method_decoder u_dec (
        .mi(mi)
    );

    // synchronised pins
    wire start_s = pin_s2_q[0];
    wire mode_sw_s = pin_s2_q[1];
    wire second_s = pin_s2_q[2];
    wire start_rise = start_s && !start_prev_q;
    // second motor follows primary when its selector is unset
    wire use_sel2 = second_s && (sel2_q != `VAL_UNSET);
    wire [15:0] cap_eff = second_s ? cap2_q : cap_q;
    wire [15:0] poles_eff = second_s ? poles2_q : poles_q;
    wire pm_eff = second_s ? type2_q : type_q;
    assign mi.sel = use_sel2 ? sel2_q : sel_q;
    assign mi.pm_motor = pm_eff;
    assign mi.mode_sw = mode_sw_s;
    assign mi.option_ok = cfg_q[`CFG_OPTION_BIT];
    // plain method flag, the only method that skips every start check
    wire is_vf = (mi.method == drive_ctl_pkg::M_VF);
    wire motor_set = (cap_eff != `VAL_UNSET) && (poles_eff != `VAL_UNSET);
    // plain method bypasses all checks
    wire cond_ok = is_vf || (mi.type_ok && motor_set);

    // bus decode
    wire wr_sel = WR && (ADDR == `OFS_METHOD_SEL);
    wire wr_freq = WR && (ADDR == `OFS_FREQ_PARAM);
    wire wr_pct = WR && (ADDR == `OFS_PERCENT_PARAM);
    wire wr_irq = WR && (ADDR == `OFS_IRQ_STATUS);
    // method before and after a primary selector write
    wire drive_ctl_pkg::method_t old_m = drive_ctl_pkg::method_of(sel_q, type_q);
    wire drive_ctl_pkg::method_t new_m = drive_ctl_pkg::method_of(WDATA, type_q);
    wire old_vec = (old_m == drive_ctl_pkg::M_VECTOR) || (old_m == drive_ctl_pkg::M_VECTOR_TEST);
    wire new_vec = (new_m == drive_ctl_pkg::M_VECTOR) || (new_m == drive_ctl_pkg::M_VECTOR_TEST);
    wire old_rsv = old_vec || (old_m == drive_ctl_pkg::M_REAL_SENSORLESS);
    wire new_rsv = new_vec || (new_m == drive_ctl_pkg::M_REAL_SENSORLESS);
    // percent rewrite only on small units under normal duty
    wire pct_gate = cfg_q[`CFG_SMALL_UNIT_BIT] && cfg_q[`CFG_NORMAL_DUTY_BIT];
    // rewrites fire only from the exact before-change value
    wire up_freq = wr_sel && drive_ctl_pkg::is_simple(old_m) && new_vec && (freq_q == `VAL_FREQ_HIGH);
    wire dn_freq = wr_sel && old_vec && drive_ctl_pkg::is_simple(new_m) && (freq_q == `VAL_FREQ_LOW);
    wire up_pct = wr_sel && pct_gate && drive_ctl_pkg::is_simple(old_m) && new_rsv &&
        (pct_q == `VAL_PERCENT_LOW);
    wire dn_pct = wr_sel && pct_gate && old_rsv && drive_ctl_pkg::is_simple(new_m) &&
        (pct_q == `VAL_PERCENT_HIGH);
    wire rewrite_ev = up_freq || dn_freq || up_pct || dn_pct;
    // start outcomes are judged only on a fresh edge in idle
    wire refuse_ev = (state_q == drive_ctl_pkg::ST_IDLE) && start_rise && !cond_ok;
    wire start_ev = (state_q == drive_ctl_pkg::ST_IDLE) && start_rise && cond_ok;

    // dependent parameter next values
    always_comb begin
        freq_d = freq_q;
        pct_d = pct_q;
        if (wr_freq) begin
            freq_d = WDATA;
        end else if (up_freq) begin
            freq_d = `VAL_FREQ_LOW;
        end else if (dn_freq) begin
            freq_d = `VAL_FREQ_HIGH;
        end
        if (wr_pct) begin
            pct_d = WDATA;
        end else if (up_pct) begin
            pct_d = `VAL_PERCENT_HIGH;
        end else if (dn_pct) begin
            pct_d = `VAL_PERCENT_LOW;
        end
    end

    // sticky status: set wins over write-one clear
    always_comb begin
        // clear first, then events, so a set in the same cycle wins
        irq_st_d = wr_irq ? (irq_st_q & ~WDATA[2:0]) : irq_st_q;
        irq_st_d[`IRQ_REFUSED_BIT] = irq_st_d[`IRQ_REFUSED_BIT] | refuse_ev;
        irq_st_d[`IRQ_STARTED_BIT] = irq_st_d[`IRQ_STARTED_BIT] | start_ev;
        irq_st_d[`IRQ_REWRITE_BIT] = irq_st_d[`IRQ_REWRITE_BIT] | rewrite_ev;
    end

    // start sequence: refusal holds until start drops
    always_comb begin
        case (state_q)
            drive_ctl_pkg::ST_IDLE: begin
                if (start_ev) begin
                    state_d = drive_ctl_pkg::ST_RUN;
                end else if (refuse_ev) begin
                    state_d = drive_ctl_pkg::ST_REFUSED;
                end else begin
                    state_d = drive_ctl_pkg::ST_IDLE;
                end
            end
            // run lasts while the synchronised start stays high
            drive_ctl_pkg::ST_RUN: state_d = start_s ? drive_ctl_pkg::ST_RUN : drive_ctl_pkg::ST_IDLE;
            // a refused start needs the pin to drop before a retry counts
            drive_ctl_pkg::ST_REFUSED: state_d = start_s ? drive_ctl_pkg::ST_REFUSED : drive_ctl_pkg::ST_IDLE;
            default: state_d = drive_ctl_pkg::ST_IDLE;
        endcase
    end

    // read mux, unmapped reads zero
    logic [15:0] rd_mux;
    always_comb begin
        case (ADDR)
            `OFS_METHOD_SEL: rd_mux = sel_q;
            `OFS_SECOND_SEL: rd_mux = sel2_q;
            `OFS_CAPACITY: rd_mux = cap_q;
            `OFS_POLES: rd_mux = poles_q;
            `OFS_MOTOR_TYPE: rd_mux = {15'h0000, type_q};
            `OFS_SECOND_CAPACITY: rd_mux = cap2_q;
            `OFS_SECOND_POLES: rd_mux = poles2_q;
            `OFS_SECOND_TYPE: rd_mux = {15'h0000, type2_q};
            `OFS_FREQ_PARAM: rd_mux = freq_q;
            `OFS_PERCENT_PARAM: rd_mux = pct_q;
            `OFS_CONFIG: rd_mux = {13'h0000, cfg_q};
            // live status: condition ok, alarm, run, mode, method
            `OFS_STATUS: rd_mux = {8'h00, cond_ok, alarm_q, run_q, mi.mode, mi.method};
            `OFS_IRQ_STATUS: rd_mux = {13'h0000, irq_st_q};
            `OFS_IRQ_MASK: rd_mux = {13'h0000, irq_mask_q};
            default: rd_mux = 16'h0000;
        endcase
    end

    // pin synchronisers
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            start_prev_q <= 1'b0;
        end else if (CE) begin
            pin_s1_q <= {SECOND_MOTOR, MODE_SWITCH, START};
            pin_s2_q <= pin_s1_q;
            start_prev_q <= start_s;
        end
    end

    // software written parameters
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sel_q <= `RST_METHOD_SEL;
            sel2_q <= `RST_SECOND_SEL;
            cap_q <= `RST_MOTOR_PARAM;
            poles_q <= `RST_MOTOR_PARAM;
            type_q <= 1'b0;
            cap2_q <= `RST_MOTOR_PARAM;
            poles2_q <= `RST_MOTOR_PARAM;
            type2_q <= 1'b0;
            cfg_q <= 3'h0;
            irq_mask_q <= 3'h0;
        end else if (CE && WR) begin
            // motor settings land as written, with no range check here
            case (ADDR)
                `OFS_METHOD_SEL: sel_q <= WDATA;
                `OFS_SECOND_SEL: sel2_q <= WDATA;
                `OFS_CAPACITY: cap_q <= WDATA;
                `OFS_POLES: poles_q <= WDATA;
                `OFS_MOTOR_TYPE: type_q <= WDATA[0];
                `OFS_SECOND_CAPACITY: cap2_q <= WDATA;
                `OFS_SECOND_POLES: poles2_q <= WDATA;
                `OFS_SECOND_TYPE: type2_q <= WDATA[0];
                `OFS_CONFIG: cfg_q <= WDATA[2:0];
                `OFS_IRQ_MASK: irq_mask_q <= WDATA[2:0];
                default: ;
            endcase
        end
    end

    // dependent parameters, events and state
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            freq_q <= `RST_FREQ_PARAM;
            pct_q <= `RST_PERCENT_PARAM;
            irq_st_q <= 3'h0;
            state_q <= drive_ctl_pkg::ST_IDLE;
        end else if (CE) begin
            freq_q <= freq_d;
            pct_q <= pct_d;
            irq_st_q <= irq_st_d;
            state_q <= state_d;
        end
    end

    // registered outputs
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_q <= 16'h0000;
            run_q <= 1'b0;
            alarm_q <= 1'b0;
            method_q <= 3'h0;
            mode_q <= 2'h0;
            irq_q <= 1'b0;
        end else if (CE) begin
            rdata_q <= RD ? rd_mux : rdata_q;
            run_q <= (state_d == drive_ctl_pkg::ST_RUN);
            alarm_q <= (state_d == drive_ctl_pkg::ST_REFUSED);
            method_q <= mi.method;
            mode_q <= mi.mode;
            irq_q <= |(irq_st_d & irq_mask_q);
        end
    end

    // outputs come straight from their flip-flops
    assign RDATA = rdata_q;
    assign RUN_PERMIT = run_q;
    assign SETTING_ERROR_ALARM = alarm_q;
    assign METHOD = method_q;
    assign MODE = mode_q;
    assign IRQ = irq_q;

    // checks
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    AST_REFUSE_ALARM: assert property (CE && refuse_ev |=> alarm_q && !run_q)
        else $error("refused start did not raise alarm");
    AST_VF_STARTS: assert property (CE && start_rise && state_q == drive_ctl_pkg::ST_IDLE && is_vf
        |=> run_q)
        else $error("plain method start was not permitted");
    AST_UNSET_BLOCKS: assert property (CE && start_rise && !is_vf && cap_eff == `VAL_UNSET
        && state_q == drive_ctl_pkg::ST_IDLE |=> !run_q)
        else $error("start allowed with unset capacity");
    AST_TYPE_BLOCKS: assert property (CE && start_rise && state_q == drive_ctl_pkg::ST_IDLE
        && mi.sel == 16'h000D && !pm_eff |=> alarm_q)
        else $error("position setting started on induction motor");
    AST_IM_TYPE: assert property (CE && start_rise && state_q == drive_ctl_pkg::ST_IDLE
        && mi.sel == 16'h000C && pm_eff |=> alarm_q)
        else $error("induction setting started on pm motor");
    AST_OPTION: assert property (CE && start_rise && state_q == drive_ctl_pkg::ST_IDLE
        && mi.sel <= 16'h0005 && !cfg_q[`CFG_OPTION_BIT] |=> alarm_q)
        else $error("vector setting started without option");
    // a refusal lasts while the start pin is held
    AST_REFUSE_HOLDS: assert property (CE && alarm_q && start_s |=> alarm_q && !run_q)
        else $error("alarm dropped while start still held");
    AST_RUN_NEEDS_OK: assert property ($rose(run_q) |-> $past(cond_ok))
        else $error("run permitted without start condition");

    // mode and method decode, one cycle behind the effective setting
    AST_MODE_SW: assert property (CE && mi.sel == 16'h0005 |=> MODE == ($past(mode_sw_s) ?
        2'(drive_ctl_pkg::MODE_TORQUE) : 2'(drive_ctl_pkg::MODE_POSITION)) || !$past(CE))
        else $error("switchover mode wrong");
    AST_TORQUE_ELEVEN: assert property (CE && mi.sel == 16'h000B
        |=> MODE == 2'(drive_ctl_pkg::MODE_TORQUE) || !$past(CE))
        else $error("setting eleven mode wrong");
    AST_POS_THIRTEEN: assert property (CE && mi.sel == 16'h000D
        |=> MODE == 2'(drive_ctl_pkg::MODE_POSITION) || !$past(CE))
        else $error("setting thirteen mode wrong");
    AST_FLUX_TWENTY: assert property (CE && mi.sel == 16'h0014
        |=> METHOD == 3'(drive_ctl_pkg::M_FLUX) || !$past(CE))
        else $error("setting twenty method wrong");

    // automatic rewrites of the dependent parameters
    AST_FREQ_UP: assert property (CE && up_freq |=> freq_q == `VAL_FREQ_LOW)
        else $error("frequency not lowered");
    AST_FREQ_DN: assert property (CE && dn_freq |=> freq_q == `VAL_FREQ_HIGH)
        else $error("frequency not raised");
    AST_PCT_UP: assert property (CE && up_pct |=> pct_q == `VAL_PERCENT_HIGH)
        else $error("percent not raised");
    AST_PCT_DN: assert property (CE && dn_pct |=> pct_q == `VAL_PERCENT_LOW)
        else $error("percent not lowered");
    AST_PCT_GATE: assert property (CE && wr_sel && !pct_gate |=> $stable(pct_q))
        else $error("percent rewritten outside small unit duty");
    AST_KEEP_OTHER: assert property (CE && wr_sel && freq_q != `VAL_FREQ_HIGH && freq_q != `VAL_FREQ_LOW
        |=> $stable(freq_q))
        else $error("frequency rewritten from other value");
    AST_KEEP_VECTOR: assert property (CE && wr_sel && !drive_ctl_pkg::is_simple(old_m)
        && !drive_ctl_pkg::is_simple(new_m) |=> $stable(freq_q))
        else $error("frequency rewritten between loop methods");
    AST_TEN_PM: assert property (CE && mi.sel == 16'h000A && pm_eff
        |=> METHOD == 3'(drive_ctl_pkg::M_PM_SENSORLESS) || !$past(CE))
        else $error("setting ten with pm motor decoded wrong");
    AST_SECOND_FOLLOWS: assert property (second_s && sel2_q == `VAL_UNSET |-> mi.sel == sel_q)
        else $error("second motor did not follow primary selector");
    COV_REFUSE: cover property (CE && refuse_ev);
    COV_START: cover property (CE && start_ev && !is_vf);
    COV_REWRITE: cover property (CE && up_freq && up_pct);
    COV_SWITCH: cover property (CE && mi.sel == 16'h000E && mode_sw_s);
endmodule

// ---- bench/terminal_model.sv ----
// far-side model of the start, mode switch and second motor terminals
`timescale 1ns/10ps
module terminal_model (
    input wire logic clk,
    input wire logic start_req,
    input wire logic msw_req,
    input wire logic sec_req,
    output logic start_pin,
    output logic msw_pin,
    output logic sec_pin
);
    // contacts start open so the block sees no start at power up
    initial begin
        start_pin = 1'b0;
        msw_pin = 1'b0;
        sec_pin = 1'b0;
    end
    // pins move just after a clock edge, as a contact that settles late
    always @(posedge clk) begin
        start_pin <= start_req; // a retry always drops the pin before raising it again
        msw_pin <= msw_req; // level chooses the mode in switchover settings
        sec_pin <= sec_req; // picks the second motor selector set
    end
endmodule

// ---- bench/tb.sv ----
// self-checking bench of the control method selector
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value at %0t: %s", $time, msg); end end
module tb;
    // one row: setting, pm motor, mode switch, method, mode, start allowed
    typedef struct packed {
        logic [7:0] sel;
        logic pm;
        logic msw;
        logic [2:0] meth;
        logic [1:0] mode;
        logic ok;
    } row_t;
    logic clk; // system clock
    logic nrst_n; // reset, active low
    logic [3:0] addr; // register index
    logic [15:0] wdata; // write data
    logic wr; // write strobe
    logic rd; // read strobe
    logic ce; // clock enable
    logic [15:0] rdata; // read data
    logic start_req, msw_req, sec_req; // requests to the terminal model
    logic start_pin, msw_pin, sec_pin; // terminal pins
    logic run_permit, alarm, irq; // block outputs
    logic [2:0] method; // decoded method
    logic [1:0] mode; // decoded mode
    int mismatches; // count of wrong values
    int checked; // count of comparisons
    int i; // row index
    row_t rows [0:22] = '{
        '{8'h00, 1'b0, 1'b0, 3'h4, 2'h0, 1'b1}, '{8'h01, 1'b0, 1'b0, 3'h4, 2'h1, 1'b1},
        '{8'h02, 1'b0, 1'b1, 3'h4, 2'h1, 1'b1}, '{8'h02, 1'b0, 1'b0, 3'h4, 2'h0, 1'b1},
        '{8'h03, 1'b0, 1'b0, 3'h4, 2'h2, 1'b1}, '{8'h04, 1'b0, 1'b1, 3'h4, 2'h2, 1'b1},
        '{8'h04, 1'b0, 1'b0, 3'h4, 2'h0, 1'b1}, '{8'h05, 1'b0, 1'b1, 3'h4, 2'h1, 1'b1},
        '{8'h05, 1'b0, 1'b0, 3'h4, 2'h2, 1'b1}, '{8'h00, 1'b1, 1'b0, 3'h4, 2'h0, 1'b0},
        '{8'h09, 1'b0, 1'b0, 3'h5, 2'h0, 1'b1}, '{8'h0A, 1'b0, 1'b0, 3'h2, 2'h0, 1'b1},
        '{8'h0A, 1'b1, 1'b0, 3'h3, 2'h0, 1'b1}, '{8'h0B, 1'b0, 1'b0, 3'h2, 2'h1, 1'b1},
        '{8'h0C, 1'b0, 1'b1, 3'h2, 2'h1, 1'b1}, '{8'h0C, 1'b1, 1'b0, 3'h2, 2'h0, 1'b0},
        '{8'h0D, 1'b1, 1'b0, 3'h3, 2'h2, 1'b1}, '{8'h0E, 1'b1, 1'b1, 3'h3, 2'h2, 1'b1},
        '{8'h0E, 1'b0, 1'b0, 3'h3, 2'h0, 1'b0}, '{8'h13, 1'b1, 1'b0, 3'h6, 2'h0, 1'b1},
        '{8'h13, 1'b0, 1'b0, 3'h6, 2'h0, 1'b0}, '{8'h14, 1'b0, 1'b0, 3'h1, 2'h0, 1'b1},
        '{8'h28, 1'b1, 1'b0, 3'h0, 2'h0, 1'b1}};

    drive_control_method_selector i_drive_control_method_selector (.CLK(clk), .NRST(nrst_n), .CE(ce),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .START(start_pin),
        .MODE_SWITCH(msw_pin), .SECOND_MOTOR(sec_pin), .RUN_PERMIT(run_permit),
        .SETTING_ERROR_ALARM(alarm), .METHOD(method), .MODE(mode), .IRQ(irq));
    terminal_model i_terminal_model (.clk(clk), .start_req(start_req), .msw_req(msw_req), .sec_req(sec_req),
        .start_pin(start_pin), .msw_pin(msw_pin), .sec_pin(sec_pin));

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // verdict and end of run, reached from the main sequence and from timeouts
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // one-cycle read strobe, data compared in the cycle after it
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, exp, "read data")
    endtask

    // raise start, wait bounded for an answer, check it, then release
    task automatic try_start(input logic ok);
        int n;
        @(posedge clk);
        start_req <= 1'b1;
        for (n = 0; n < 12 && !(run_permit === 1'b1 || alarm === 1'b1); n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 12) begin
            mismatches++;
            $display("wrong value at %0t: no start answer", $time);
            test_done();
        end
        `CHK(run_permit, ok, "run permit")
        `CHK(alarm, ~ok, "setting error alarm")
        start_req <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    // main sequence
    initial begin
        nrst_n = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        ce = 1'b1;
        start_req = 1'b0;
        msw_req = 1'b0;
        sec_req = 1'b0;
        mismatches = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        nrst_n <= 1'b1;
        wr_reg(4'h2, 16'h0001);
        wr_reg(4'h3, 16'h0004);
        wr_reg(4'hA, 16'h0007); // option fitted before any vector setting
        // table of methods, modes and start checks
        for (i = 0; i < 23; i++) begin
            wr_reg(4'h4, {15'h0000, rows[i].pm});
            wr_reg(4'h0, {8'h00, rows[i].sel});
            msw_req <= rows[i].msw;
            repeat (6) @(posedge clk);
            #1;
            `CHK(method, rows[i].meth, "method")
            `CHK(mode, rows[i].mode, "mode")
            try_start(rows[i].ok);
        end
        // unset capacity or poles block every method but the plain one
        wr_reg(4'h4, 16'h0000);
        wr_reg(4'hD, 16'h0001);
        wr_reg(4'h2, 16'h270F);
        wr_reg(4'h0, 16'h0000);
        try_start(1'b0);
        wr_reg(4'h0, 16'h0028);
        try_start(1'b1);
        wr_reg(4'h2, 16'h0001);
        wr_reg(4'h3, 16'h270F);
        wr_reg(4'h0, 16'h0014);
        wr_reg(4'hC, 16'h0007); // stale events of the table cleared first
        @(posedge clk);
        start_req <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        `CHK(irq, 1'b1, "interrupt on refusal")
        `CHK(alarm, 1'b1, "alarm with unset poles")
        start_req <= 1'b0;
        rd_chk(4'hC, 16'h0001);
        wr_reg(4'hC, 16'h0001);
        #1;
        `CHK(irq, 1'b0, "interrupt cleared")
        wr_reg(4'h3, 16'h0004);
        wr_reg(4'hA, 16'h0006);
        wr_reg(4'h0, 16'h0003);
        try_start(1'b0);
        wr_reg(4'hA, 16'h0007);
        // automatic rewrites of the dependent parameters
        wr_reg(4'h0, 16'h0028);
        wr_reg(4'h8, 16'h012C);
        wr_reg(4'h9, 16'h0096);
        wr_reg(4'h0, 16'h0000);
        rd_chk(4'h8, 16'h0032);
        rd_chk(4'h9, 16'h00C8);
        wr_reg(4'h0, 16'h0014);
        rd_chk(4'h8, 16'h012C);
        rd_chk(4'h9, 16'h0096);
        wr_reg(4'h0, 16'h000B);
        rd_chk(4'h8, 16'h012C);
        rd_chk(4'h9, 16'h00C8);
        wr_reg(4'h0, 16'h0028);
        rd_chk(4'h9, 16'h0096);
        wr_reg(4'h8, 16'h0100);
        wr_reg(4'h0, 16'h0000);
        rd_chk(4'h8, 16'h0100);
        rd_chk(4'hE, 16'h0000);
        // a write while the clock enable is low is ignored
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(4'h8, 16'h0055);
        ce <= 1'b1;
        rd_chk(4'h8, 16'h0100);
        // second reset in mid-run, then reset values
        @(posedge clk);
        nrst_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        `CHK(run_permit | alarm | irq, 1'b0, "outputs in reset")
        nrst_n <= 1'b1;
        rd_chk(4'h0, 16'h0028);
        rd_chk(4'h1, 16'h270F);
        rd_chk(4'h8, 16'h012C);
        rd_chk(4'h9, 16'h0096);
        // second motor with default selector follows the primary one
        wr_reg(4'hA, 16'h0001);
        wr_reg(4'h0, 16'h0001);
        sec_req <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        `CHK(method, 3'h4, "second motor method")
        `CHK(mode, 2'h1, "second motor mode")
        // a set second selector takes over: plain method, start condition ok
        wr_reg(4'h1, 16'h0028);
        rd_chk(4'hB, 16'h0080);
        `CHK(method, 3'h0, "second selector method")
        test_done();
    end
endmodule
